// ### rtl/timer_pwm_pkg.sv
// package: shared constants and types of the timer/counter/pwm unit
// assumes: one clock domain, plain-port configuration
package timer_pwm_pkg;
  typedef enum logic [5:0] {
    MODE_COMPARE = 6'h01,
    MODE_CAPTURE = 6'h02,
    MODE_QUAD = 6'h04,
    MODE_PWM = 6'h08,
    MODE_PRPWM = 6'h10,
    MODE_PWMDT = 6'h20
  } mode_e;
  localparam logic [1:0] DIR_UP = 2'h0;
  localparam logic [1:0] DIR_DOWN = 2'h1;
  localparam logic [1:0] DIR_UPDOWN = 2'h2;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [1:0] EDGE_LEVEL = 2'h3;
  localparam int PRESCALE_W = 7;
  localparam logic [2:0] PRESCALE_MAX = 3'h7;
  localparam int DEADTIME_W = 8;
  localparam int NUM_TRIG = 6;
  // trigger indices
  localparam int TRG_START = 0;
  localparam int TRG_RELOAD = 1;
  localparam int TRG_STOP = 2;
  localparam int TRG_COUNT = 3;
  localparam int TRG_CAPTURE = 4;
  localparam int TRG_KILL = 5;
  typedef struct packed {
    mode_e mode;
    logic [1:0] direction;
    logic [2:0] prescale;
    logic killLevel;
    logic [DEADTIME_W-1:0] deadTime;
    logic [NUM_TRIG*2-1:0] trigEdge;
  } config_s;
  typedef struct packed {
    logic overflow;
    logic underflow;
    logic ccMatch;
    logic tcIrq;
    logic ccIrq;
  } events_s;
endpackage : timer_pwm_pkg

// ### rtl/trigger_detect.sv
// trigger_detect: edge/level detector for one event input
// assumes: input already synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module trigger_detect
  import timer_pwm_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic trigIn,
  input wire logic [1:0] edgeSel,
  output logic event_
);
  logic prev;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev <= 1'b0;
    end else begin
      prev <= trigIn;
    end
  end
  always_comb begin
    case (edgeSel)
      EDGE_RISE: event_ = trigIn & ~prev;
      EDGE_FALL: event_ = ~trigIn & prev;
      EDGE_BOTH: event_ = trigIn ^ prev;
      default: event_ = trigIn;
    endcase
  end
endmodule : trigger_detect
`default_nettype wire

// ### rtl/timer_pwm_unit.sv
// timer_pwm_unit: multi-mode timer / counter / pwm with triggers
// assumes: config, buffers and triggers synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module timer_pwm_unit
  import timer_pwm_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire config_s cfg,
  input wire logic [WIDTH-1:0] periodBuf,
  input wire logic [WIDTH-1:0] compareBuf,
  input wire logic [NUM_TRIG-1:0] trigIn,
  input wire logic quadA,
  input wire logic quadB,
  output logic [WIDTH-1:0] count,
  output logic [WIDTH-1:0] captureValue,
  output logic running,
  output events_s events,
  output logic pwmOut,
  output logic pwmOutN
);
  logic [NUM_TRIG-1:0] trig;
  logic [WIDTH-1:0] period;
  logic [WIDTH-1:0] compare;
  logic [PRESCALE_W-1:0] preCnt;
  logic tick;
  logic downPhase;
  logic qaPrev;
  logic qbPrev;
  logic [WIDTH-1:0] lfsr;
  logic rawPwm;
  logic rawPrev;
  logic [DEADTIME_W-1:0] dtCnt;
  logic deadBand;
  logic isPwm;
  logic ovf;
  logic unf;
  logic match;
  logic step;
  logic stepDown;
  logic quadStep;
  logic quadDir;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TRIG; gi++) begin : g_trig
      trigger_detect u_det (
        .clk(clk),
        .reset_n(reset_n),
        .trigIn(trigIn[gi]),
        .edgeSel(cfg.trigEdge[gi*2 +: 2]),
        .event_(trig[gi])
      );
    end
  endgenerate

  assign isPwm = (cfg.mode == MODE_PWM) | (cfg.mode == MODE_PRPWM) | (cfg.mode == MODE_PWMDT);

  // prescaler: tick every 2**prescale clocks
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      preCnt <= '0;
    end else if (!running) begin
      preCnt <= '0;
    end else begin
      preCnt <= preCnt + 1'b1;
    end
  end
  always_comb begin
    tick = running & ((preCnt & PRESCALE_W'((1 << cfg.prescale) - 1)) == '0);
  end

  // quadrature decode: one step per edge of either phase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      qaPrev <= 1'b0;
      qbPrev <= 1'b0;
    end else begin
      qaPrev <= quadA;
      qbPrev <= quadB;
    end
  end
  assign quadStep = (quadA ^ qaPrev) | (quadB ^ qbPrev);
  assign quadDir = quadA ^ qbPrev;

  // step enable and direction per mode
  always_comb begin
    step = 1'b0;
    stepDown = 1'b0;
    case (cfg.mode)
      MODE_QUAD: begin
        step = running & quadStep;
        stepDown = ~quadDir;
      end
      MODE_COMPARE, MODE_CAPTURE: begin
        step = tick & ((cfg.trigEdge[TRG_COUNT*2 +: 2] == EDGE_LEVEL) ? trig[TRG_COUNT] : 1'b1);
        stepDown = (cfg.direction == DIR_DOWN) | ((cfg.direction == DIR_UPDOWN) & downPhase);
      end
      default: begin
        step = tick;
        stepDown = (cfg.direction == DIR_DOWN) | ((cfg.direction == DIR_UPDOWN) & downPhase);
      end
    endcase
  end

  assign ovf = step & ~stepDown & (count == period);
  assign unf = step & stepDown & (count == '0);
  assign match = step & (count == compare) & (cfg.mode != MODE_CAPTURE);

  // run control from start/stop triggers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      running <= 1'b0;
    end else if (!enable || trig[TRG_STOP]) begin
      running <= 1'b0;
    end else if (trig[TRG_START] || trig[TRG_RELOAD]) begin
      running <= 1'b1;
    end
  end

  // counter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      downPhase <= 1'b0;
    end else if (trig[TRG_RELOAD] || (!running && trig[TRG_START])) begin
      count <= (cfg.direction == DIR_DOWN) ? periodBuf : '0;
      downPhase <= 1'b0;
    end else if (ovf) begin
      if (cfg.direction == DIR_UPDOWN) begin
        count <= count - 1'b1;
        downPhase <= 1'b1;
      end else begin
        count <= '0;
      end
    end else if (unf) begin
      if (cfg.direction == DIR_UPDOWN) begin
        count <= count + 1'b1;
        downPhase <= 1'b0;
      end else begin
        count <= period;
      end
    end else if (step) begin
      count <= stepDown ? count - 1'b1 : count + 1'b1;
    end
  end

  // active period/compare from buffers at terminal count
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      period <= '0;
      compare <= '0;
    end else if (ovf || unf || !running || trig[TRG_RELOAD]) begin
      period <= periodBuf;
      compare <= compareBuf;
    end
  end

  // capture of running count
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      captureValue <= '0;
    end else if (cfg.mode == MODE_CAPTURE && trig[TRG_CAPTURE]) begin
      captureValue <= count;
    end
  end

  // pseudo-random source: galois lfsr
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lfsr <= WIDTH'(1);
    end else if (tick) begin
      lfsr <= {1'b0, lfsr[WIDTH-1:1]} ^ (lfsr[0] ? {2'b11, (WIDTH-2)'(0)} | WIDTH'(1 << (WIDTH/2)) : '0);
    end
  end

  always_comb begin
    if (cfg.mode == MODE_PRPWM) begin
      rawPwm = running & (lfsr < compare);
    end else begin
      rawPwm = running & (count < compare);
    end
  end

  // dead time counter on each raw edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rawPrev <= 1'b0;
      dtCnt <= '0;
    end else begin
      rawPrev <= rawPwm;
      if (rawPwm != rawPrev && cfg.mode == MODE_PWMDT) begin
        dtCnt <= cfg.deadTime;
      end else if (dtCnt != '0) begin
        dtCnt <= dtCnt - 1'b1;
      end
    end
  end

  // both outputs held off from the raw edge for deadTime clocks
  always_comb begin
    if (cfg.mode == MODE_PWMDT && rawPwm != rawPrev) begin
      deadBand = (cfg.deadTime != '0);
    end else begin
      deadBand = (dtCnt > DEADTIME_W'(1));
    end
  end

  // waveform outputs, kill overrides comparison
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwmOut <= 1'b0;
      pwmOutN <= 1'b0;
    end else if (trig[TRG_KILL]) begin
      pwmOut <= cfg.killLevel;
      pwmOutN <= cfg.killLevel;
    end else if (isPwm) begin
      pwmOut <= rawPwm & ~deadBand;
      pwmOutN <= ~rawPwm & ~deadBand;
    end else begin
      pwmOut <= rawPwm;
      pwmOutN <= 1'b0;
    end
  end

  // event outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      events <= '0;
    end else begin
      events.overflow <= ovf;
      events.underflow <= unf;
      events.ccMatch <= match | (cfg.mode == MODE_CAPTURE && trig[TRG_CAPTURE]);
      events.tcIrq <= ovf | unf;
      events.ccIrq <= match | (cfg.mode == MODE_CAPTURE && trig[TRG_CAPTURE]);
    end
  end

  a_tc_irq: assert property (@(posedge clk) disable iff (!reset_n)
    (ovf | unf) |=> events.tcIrq) else $error("terminal count irq missing");
  a_ovf_out: assert property (@(posedge clk) disable iff (!reset_n)
    ovf |=> events.overflow && !events.underflow) else $error("overflow pulse wrong");
  a_unf_wrap: assert property (@(posedge clk) disable iff (!reset_n)
    (unf && cfg.direction == DIR_DOWN && !trig[TRG_RELOAD]) |=> count == $past(period))
    else $error("underflow reload wrong");
  a_kill_out: assert property (@(posedge clk) disable iff (!reset_n)
    trig[TRG_KILL] |=> pwmOut == $past(cfg.killLevel)) else $error("kill not applied");
  a_capture_val: assert property (@(posedge clk) disable iff (!reset_n)
    (cfg.mode == MODE_CAPTURE && trig[TRG_CAPTURE]) |=> captureValue == $past(count) && events.ccIrq)
    else $error("capture wrong");
  a_buf_load: assert property (@(posedge clk) disable iff (!reset_n)
    ovf |=> period == $past(periodBuf)) else $error("buffer not loaded");
  a_comp_excl: assert property (@(posedge clk) disable iff (!reset_n)
    (isPwm && !trig[TRG_KILL]) |=> !(pwmOut && pwmOutN)) else $error("outputs overlap");
  sequence s_halted;
    !running ##1 $stable(count);
  endsequence
  a_stop_halts: assert property (@(posedge clk) disable iff (!reset_n)
    (trig[TRG_STOP] && cfg.mode != MODE_QUAD) |=> s_halted)
    else $error("stop ignored");
endmodule : timer_pwm_unit
`default_nettype wire

// ### tb/trigger_source.sv
// trigger_source: far-side model driving the trigger lines
// assumes: bench changes request at the falling edge
`timescale 1ns/10ps
`default_nettype none
module trigger_source (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [5:0] request,
  output logic [5:0] trigIn
);
  // each request stands a full clock, so edges are seen
  always_ff @(negedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trigIn <= 6'h00;
    end else begin
      trigIn <= request;
    end
  end
endmodule : trigger_source
`default_nettype wire

// ### tb/timer_counter_pwm_unit_test.sv
// testbench: timer/pwm unit, 16-bit build
// assumes: trigger_source model on the trigger inputs
`timescale 1ns/10ps
`default_nettype none
module timer_counter_pwm_unit_test;
  import timer_pwm_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic enable = 1'b0;
  config_s cfg;
  logic [15:0] periodBuf = 16'h0005;
  logic [15:0] compareBuf = 16'h0003;
  logic [5:0] request = 6'h00;
  logic [5:0] trigIn;
  logic quadA = 1'b0;
  logic quadB = 1'b0;
  logic [15:0] count;
  logic [15:0] captureValue;
  logic running;
  logic pwmOut;
  logic pwmOutN;
  events_s events;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  int k;
  logic [15:0] c0;
  always #12.5 clk = ~clk;
  trigger_source u_src (.clk(clk), .reset_n(reset_n), .request(request), .trigIn(trigIn));
  timer_pwm_unit #(.WIDTH(16)) u_dut (.clk(clk), .reset_n(reset_n), .enable(enable), .cfg(cfg),
    .periodBuf(periodBuf), .compareBuf(compareBuf), .trigIn(trigIn), .quadA(quadA), .quadB(quadB),
    .count(count), .captureValue(captureValue), .running(running), .events(events),
    .pwmOut(pwmOut), .pwmOutN(pwmOutN));
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic evt(input int sel);
    case (sel)
      0: return events.overflow === 1'b1;
      1: return events.underflow === 1'b1;
      default: return events.ccMatch === 1'b1;
    endcase
  endfunction : evt
  // cycles between two pulses of one event output
  task automatic gap(input int sel, output int m);
    int t;
    t = 0;
    m = 1;
    while (!evt(sel) && t < 2000) begin
      @(negedge clk);
      t++;
    end
    @(negedge clk);
    while (!evt(sel) && m < 2000) begin
      @(negedge clk);
      m++;
    end
  endtask : gap
  task automatic pulse(input int idx);
    request[idx] <= 1'b1;
    @(negedge clk);
    request[idx] <= 1'b0;
    repeat (3) @(negedge clk);
  endtask : pulse
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    cfg = '{mode: MODE_COMPARE, direction: DIR_UP, prescale: 3'h0, killLevel: 1'b1,
      deadTime: 8'h00, trigEdge: 12'h000};
    cfg.trigEdge[11:10] = EDGE_LEVEL;
    repeat (3) @(negedge clk);
    chk({count, running, events, pwmOut, pwmOutN}, 32'h0);
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    enable = 1'b1;
    @(negedge clk);
    pulse(TRG_START);
    chk(running, 1'b1);
    gap(0, n);
    chk(n, 6);
    chk(events.tcIrq, 1'b1);
    gap(2, n);
    chk(n, 6);
    chk(events.ccIrq, 1'b1);
    for (k = 1; k < 8; k++) begin
      cfg.prescale = k[2:0];
      gap(0, n);
      gap(0, n);
      chk(n, 6 << k);
    end
    cfg.prescale = 3'h0;
    periodBuf = 16'h0009;
    gap(0, n);
    gap(0, n);
    chk(n, 10);
    cfg.direction = DIR_DOWN;
    gap(1, n);
    gap(1, n);
    chk(n, 10);
    cfg.direction = DIR_UPDOWN;
    gap(1, n);
    gap(1, n);
    chk(n, 18);
    pulse(TRG_STOP);
    chk(running, 1'b0);
    c0 = count;
    repeat (5) @(negedge clk);
    chk(count, c0);
    cfg.mode = MODE_CAPTURE;
    cfg.direction = DIR_UP;
    pulse(TRG_START);
    request[TRG_CAPTURE] <= 1'b1;
    n = 0;
    repeat (4) begin
      @(negedge clk);
      n = n | evt(3) | (events.ccIrq === 1'b1);
    end
    request[TRG_CAPTURE] <= 1'b0;
    chk(n, 1);
    chk(captureValue, 16'h0003);
    cfg.mode = MODE_PWM;
    n = 0;
    repeat (20) begin
      @(negedge clk);
      chk({pwmOut, pwmOutN}, pwmOut ? 2'h2 : 2'h1);
      n = n + pwmOut;
    end
    chk(n, 6);
    cfg.mode = MODE_PRPWM;
    repeat (10) begin
      @(negedge clk);
      chk(pwmOut ^ pwmOutN, 1'b1);
    end
    request[TRG_KILL] <= 1'b1;
    repeat (3) @(negedge clk);
    repeat (4) begin
      chk({pwmOut, pwmOutN}, 2'h3);
      @(negedge clk);
    end
    request[TRG_KILL] <= 1'b0;
    repeat (2) @(negedge clk);
    cfg.mode = MODE_PWMDT;
    cfg.deadTime = 8'h02;
    n = 0;
    for (k = 0; k < 30; k++) begin
      @(negedge clk);
      chk(pwmOut & pwmOutN, 1'b0);
      if (k >= 10) begin
        n = n + (!pwmOut && !pwmOutN);
      end
    end
    chk(n, 8);
    cfg.mode = MODE_QUAD;
    c0 = count;
    repeat (3) begin
      quadA <= 1'b1;
      repeat (2) @(negedge clk);
      quadB <= 1'b1;
      repeat (2) @(negedge clk);
      quadA <= 1'b0;
      repeat (2) @(negedge clk);
      quadB <= 1'b0;
      repeat (2) @(negedge clk);
    end
    chk(count, (c0 + 12) % 10);
    cfg.trigEdge[3:2] = EDGE_FALL;
    request[TRG_RELOAD] <= 1'b1;
    repeat (3) @(negedge clk);
    chk(count, (c0 + 12) % 10);
    request[TRG_RELOAD] <= 1'b0;
    repeat (3) @(negedge clk);
    chk(count, 16'h0000);
    final_report();
  end
endmodule : timer_counter_pwm_unit_test
`default_nettype wire
